// [flash_ctl_pkg.sv]
package flash_ctl_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ------------------------------------------------------------
  localparam logic [7:0] addr_low_off   = 8'h00; // flash_address_low
  localparam logic [7:0] addr_high_off  = 8'h04; // flash_address_high
  localparam logic [7:0] control_off    = 8'h08; // flash_control
  localparam logic [7:0] irq_status_off = 8'h0c; // sticky events, read clears
  localparam logic [7:0] irq_mask_off   = 8'h10; // event mask
  localparam logic [7:0] read_data_off  = 8'h14; // last word read from flash

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int ctl_unimpl_bit = 7; // reads as one
  localparam int ctl_cfg_bit    = 6; // config_space_select
  localparam int ctl_latch_bit  = 5; // latch_only_load
  localparam int ctl_erase_bit  = 4; // erase select, hardware clears
  localparam int ctl_err_bit    = 3; // program_error_flag
  localparam int ctl_en_bit     = 2; // program_enable
  localparam int ctl_wr_bit     = 1; // start-write, set only
  localparam int ctl_rd_bit     = 0; // start-read, set only

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  addr_low_rst  = 8'h00;
  localparam logic [6:0]  addr_high_rst = 7'h00;
  localparam logic [31:0] mask_rst      = 32'h0000_0000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int clk_mhz       = 200;
  localparam int prog_time_us  = 2;   // self-timed write/erase length
  localparam int prog_cycles   = prog_time_us * clk_mhz;
  localparam int timer_w       = 16;

  // interrupt event bits
  localparam int ev_write_done = 0;
  localparam int ev_erase_done = 1;
  localparam int ev_read_done  = 2;
  localparam int ev_inhibited  = 3;

  // command towards the flash array
  typedef struct packed {
    logic        rd;     // one-cycle read strobe
    logic        wr;     // program strobe level
    logic        er;     // erase strobe level
    logic        cfg;    // configuration space
    logic        latch;  // load latches only
    logic [14:0] addr;   // word address
  } flash_cmd_t;

  typedef enum logic [1:0] {idle_s, busy_s} seq_state_t;

endpackage

// [flash_op_timer.sv]
module flash_op_timer
  import flash_ctl_pkg::*;
#(
  parameter int width = timer_w
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             start,
  input  wire logic [width-1:0] cycles,
  output logic                  done
);
  // --------------------------------------------------------------
  // one-shot down counter
  // --------------------------------------------------------------
  logic [width-1:0] count_r;   // remaining cycles
  logic             run_r;     // counting
  wire              last = run_r && (count_r == '0);

  // done pulses for one cycle when the count runs out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      run_r   <= 1'b0;
    end else if (start) begin
      count_r <= cycles - width'(1);
      run_r   <= 1'b1;
    end else if (last) begin
      run_r   <= 1'b0;
    end else if (run_r) begin
      count_r <= count_r - width'(1);
    end
  end

  assign done = last;
endmodule

// [program_flash_write_control.sv]
// Contract
// - low byte gives flash address bits 7:0
// - high byte bits 6:0 give address 14:8
// - unimplemented bit 7s read one, ignore writes
// - program and erase need program_enable set
// - error flag set whenever a write starts
//
// The address map and the AXI4-Lite register port were decided locally.
module program_flash_write_control
  import flash_ctl_pkg::*;
#(
  parameter int prog_len = prog_cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output flash_cmd_t       flash_cmd,
  input  wire logic [13:0] flash_rdata,
  output logic             irq
);
  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [7:0]  addr_low_r;    // address bits 7:0
  logic [6:0]  addr_high_r;   // address bits 14:8
  logic        cfg_r;         // config_space_select
  logic        latch_r;       // latch_only_load
  logic        erase_r;       // erase select
  logic        err_r;         // program_error_flag
  logic        en_r;          // program_enable
  logic        wr_r;          // start-write busy
  logic        rd_r;          // start-read busy
  logic [3:0]  status_r;      // sticky events
  logic [3:0]  mask_r;        // event mask
  logic [13:0] rdata_r;       // captured flash word
  seq_state_t  state_r;       // sequencer state
  logic        op_erase_r;    // running op is an erase

  // --------------------------------------------------------------
  // write channel: address and data taken together, either order
  // --------------------------------------------------------------
  logic [7:0]  awaddr_r;      // held write address
  logic        aw_have_r;     // address held
  logic [31:0] wdata_r;       // held write data
  logic [3:0]  wstrb_r;       // held strobes
  logic        w_have_r;      // data held

  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire wr_fire   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire lane0     = wstrb_r[0];
  wire wr_ctl    = wr_fire && lane0 && (awaddr_r == control_off);
  wire wr_lo     = wr_fire && lane0 && (awaddr_r == addr_low_off);
  wire wr_hi     = wr_fire && lane0 && (awaddr_r == addr_high_off);
  wire wr_mask   = wr_fire && lane0 && (awaddr_r == irq_mask_off);
  wire wr_known  = (awaddr_r == control_off) || (awaddr_r == addr_low_off) ||
                   (awaddr_r == addr_high_off) || (awaddr_r == irq_mask_off);
  wire [7:0] wb  = wdata_r[7:0];

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;

  // hold address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // sequencer decisions
  // --------------------------------------------------------------
  wire        idle      = (state_r == idle_s);
  wire        go_wr     = wr_ctl && wb[ctl_wr_bit] && idle;
  wire        go_rd     = wr_ctl && wb[ctl_rd_bit] && !wb[ctl_wr_bit] && idle;
  wire        en_now    = wb[ctl_en_bit];
  // a start only proceeds with program_enable in the same write
  wire        go_prog   = go_wr && en_now;
  wire        inhibit   = go_wr && !en_now;
  wire        timer_done;
  wire        prog_end  = (state_r == busy_s) && timer_done;

  flash_op_timer #(.width(timer_w)) flash_op_timer_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (go_prog),
    .cycles  (timer_w'(prog_len)),
    .done    (timer_done)
  );

  // --------------------------------------------------------------
  // control register and sequencer
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_low_r  <= addr_low_rst;
      addr_high_r <= addr_high_rst;
      cfg_r       <= 1'b0;
      latch_r     <= 1'b0;
      erase_r     <= 1'b0;
      err_r       <= 1'b0;
      en_r        <= 1'b0;
      wr_r        <= 1'b0;
      rd_r        <= 1'b0;
      state_r     <= idle_s;
      op_erase_r  <= 1'b0;
    end else begin
      if (wr_lo) addr_low_r <= wb;
      if (wr_hi) addr_high_r <= wb[6:0];
      if (wr_ctl && idle) begin
        cfg_r   <= wb[ctl_cfg_bit];
        latch_r <= wb[ctl_latch_bit];
        erase_r <= wb[ctl_erase_bit];
        err_r   <= wb[ctl_err_bit];
        en_r    <= wb[ctl_en_bit];
      end else if (wr_ctl) begin
        en_r    <= wb[ctl_en_bit];  // enable stays writable while busy
      end
      // start bits only ever set by software
      if (go_prog) begin
        wr_r       <= 1'b1;
        err_r      <= 1'b1;
        op_erase_r <= wb[ctl_erase_bit];
        state_r    <= busy_s;
      end
      if (inhibit) err_r <= 1'b1;
      if (go_rd) rd_r <= 1'b1;
      if (rd_r) rd_r <= 1'b0;
      if (prog_end) begin
        wr_r    <= 1'b0;
        state_r <= idle_s;
        if (op_erase_r) erase_r <= 1'b0;
      end
    end
  end

  // read captures the flash word one cycle after start
  always_ff @(posedge aclk) begin
    if (!aresetn) rdata_r <= 14'h0000;
    else if (rd_r) rdata_r <= flash_rdata;
  end

  // --------------------------------------------------------------
  // flash command, registered
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.addr  <= {addr_high_r, addr_low_r};
      flash_cmd.cfg   <= cfg_r;
      flash_cmd.latch <= latch_r;
      flash_cmd.rd    <= go_rd;
      flash_cmd.wr    <= (go_prog && !wb[ctl_erase_bit]) ||
                         (flash_cmd.wr && !prog_end);
      flash_cmd.er    <= (go_prog && wb[ctl_erase_bit]) ||
                         (flash_cmd.er && !prog_end);
    end
  end

  // --------------------------------------------------------------
  // read channel and interrupts
  // --------------------------------------------------------------
  wire [7:0] ctl_view = {1'b1, cfg_r, latch_r, erase_r, err_r, en_r, wr_r, rd_r};
  wire       ar_take  = s_axi_arvalid && s_axi_arready;
  wire       rd_stat  = ar_take && (s_axi_araddr == irq_status_off);
  wire [3:0] events   = {inhibit, rd_r, prog_end && op_erase_r, prog_end && !op_erase_r};
  logic [31:0] rmux;
  logic        rknown;

  assign s_axi_arready = !s_axi_rvalid;

  // read data selection
  always_comb begin
    rknown = 1'b1;
    unique case (s_axi_araddr)
      addr_low_off:   rmux = {24'h000000, addr_low_r};
      addr_high_off:  rmux = {24'h000000, 1'b1, addr_high_r};
      control_off:    rmux = {24'h000000, ctl_view};
      irq_status_off: rmux = {28'h0000000, status_r};
      irq_mask_off:   rmux = {28'h0000000, mask_r};
      read_data_off:  rmux = {18'h00000, rdata_r};
      default: begin
        rmux   = 32'h0000_0000;
        rknown = 1'b0;
      end
    endcase
  end

  // read response, status cleared on read but new events win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
      status_r     <= 4'h0;
      mask_r       <= mask_rst[3:0];
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= rknown ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      status_r <= (rd_stat ? 4'h0 : status_r) | events;
      if (wr_mask) mask_r <= wb[3:0];
    end
  end

  assign irq = |(status_r & mask_r);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_err_on_start: assert property (@(posedge aclk) disable iff (!aresetn)
    go_prog |=> ctl_view[ctl_err_bit] && wr_r)
    else $error("error flag not set at write start");
  a_no_prog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    inhibit |=> !flash_cmd.wr && !flash_cmd.er && !wr_r)
    else $error("program ran without enable");
  a_wr_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_end |=> !wr_r)
    else $error("start-write not cleared at end");
  a_rd_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    go_rd |=> rd_r ##1 !rd_r)
    else $error("start-read not one cycle");
  a_erase_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_end && op_erase_r |=> !erase_r)
    else $error("erase select not cleared");
  a_erase_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
    go_prog && wb[ctl_erase_bit] |=> flash_cmd.er && !flash_cmd.wr)
    else $error("erase strobe wrong");
  a_addr_low: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lo |=> ##1 flash_cmd.addr[7:0] == $past(wb, 2))
    else $error("low address not applied");
  a_addr_high: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hi |=> ##1 flash_cmd.addr[14:8] == $past(wb[6:0], 2))
    else $error("high address not applied");
  a_unimpl_one: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && (s_axi_araddr == control_off || s_axi_araddr == addr_high_off)
      |=> s_axi_rdata[7])
    else $error("unimplemented bit not one");
endmodule

// [program_flash_write_control_bench.sv]
module program_flash_write_control_bench
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  localparam int plen = 8;    // short program time for sim
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  flash_cmd_t  flash_cmd;
  logic [13:0] flash_rdata;   // constant word the array returns
  logic [14:0] op_addr;       // address seen during an operation
  int          n_errors, checks, wr_cnt, er_cnt, rd_cnt;

  program_flash_write_control #(.prog_len(plen)) program_flash_write_control_inst (.*);

  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  // catches a hung handshake; the run needs far fewer cycles
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end

  // count strobe cycles seen at the array side
  always @(negedge aclk) begin
    if (flash_cmd.wr) wr_cnt++;
    if (flash_cmd.er) er_cnt++;
    if (flash_cmd.wr || flash_cmd.er) op_addr = flash_cmd.addr;
    if (flash_cmd.rd) rd_cnt++;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // handshakes are sampled at the falling edge, released on the next rise
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, aw_hit, w_hit, b_hit;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do begin
      @(negedge aclk);
      b_hit = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!b_hit);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      hit = s_axi_arready;
      @(posedge aclk);
    end while (!hit);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      hit = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!hit);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(what, d, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge aclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // polls until the start bit drops, bounded
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 40; i++) begin
      axi_read(control_off, d, r);
      if (d[ctl_wr_bit] === 1'b0) break;
    end
    chk("write finished", d[ctl_wr_bit], 1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    reg_chk(addr_low_off, 32'h00, "low after reset");
    reg_chk(addr_high_off, 32'h80, "high after reset");
    reg_chk(control_off, 32'h80, "control after reset");
    irq_chk(1'b0);
  endtask

  task automatic t_addr();
    wr(addr_low_off, 32'ha5);
    wr(addr_high_off, 32'h7f);
    reg_chk(addr_low_off, 32'ha5, "low byte");
    reg_chk(addr_high_off, 32'hff, "high byte");
  endtask

  // program cycle, then interrupt masking and read-clear
  task automatic t_write();
    wr_cnt = 0;
    er_cnt = 0;
    wr(control_off, 32'h06);
    reg_chk(control_off, 32'h8e, "control busy");
    wait_idle();
    chk("write strobe", wr_cnt, plen);
    chk("erase strobe", er_cnt, 0);
    chk("flash address", {17'h0, op_addr}, 32'h7fa5);
    reg_chk(control_off, 32'h8c, "control done");
    irq_chk(1'b0);
    wr(irq_mask_off, 32'h01);
    irq_chk(1'b1);
    reg_chk(irq_status_off, 32'h01, "write event");
    irq_chk(1'b0);
  endtask

  task automatic t_erase();
    wr_cnt = 0;
    er_cnt = 0;
    wr(control_off, 32'h16);
    reg_chk(control_off, 32'h9e, "erase busy");
    wait_idle();
    chk("erase strobe", er_cnt, plen);
    chk("write strobe", wr_cnt, 0);
    reg_chk(control_off, 32'h8c, "erase select cleared");
    reg_chk(irq_status_off, 32'h02, "erase event");
  endtask

  // start without enable must not touch the array
  task automatic t_inhibit();
    wr(control_off, 32'h00);
    reg_chk(control_off, 32'h80, "error cleared");
    wr_cnt = 0;
    er_cnt = 0;
    wr(control_off, 32'h02);
    repeat (plen + 4) @(posedge aclk);
    chk("inhibited strobes", wr_cnt + er_cnt, 0);
    reg_chk(control_off, 32'h88, "inhibited control");
    reg_chk(irq_status_off, 32'h08, "inhibit event");
  endtask

  task automatic t_read();
    rd_cnt = 0;
    wr(control_off, 32'h61);
    reg_chk(control_off, 32'he0, "read bit cleared");
    chk("read strobes", rd_cnt, 1);
    chk("cfg and latch", {30'h0, flash_cmd.cfg, flash_cmd.latch}, 32'h3);
    reg_chk(read_data_off, 32'h2b3c, "read word");
    reg_chk(irq_status_off, 32'h04, "read event");
  endtask

  // reset in mid program cycle must stop the strobe and clear registers
  task automatic t_midreset();
    wr(control_off, 32'h06);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("strobe after reset", {31'h0, flash_cmd.wr}, 32'h0);
    reg_chk(control_off, 32'h80, "control after mid reset");
    reg_chk(addr_high_off, 32'h80, "high after mid reset");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h18, 32'hff, r);
    chk("unmapped bresp", r, 2'b10);
    axi_read(8'h18, d, r);
    chk("unmapped rresp", r, 2'b10);
    chk("unmapped rdata", d, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence and verdict
  // ----------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    flash_rdata = 14'h2b3c;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_addr();
    t_write();
    t_erase();
    t_inhibit();
    t_read();
    t_midreset();
    t_unmapped();
    print_verdict();
  end
endmodule
